/* common/synth_ctrl_regs.svh */
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH
`define ADDR_FIXED 5'h18
`define CTL_PUMP_CUR_BIT 6
`define CTL_TEST_BIT 5
`define CTL_PUMP_DIS_BIT 4
`define CTL_AMP_OFF_BIT 0
`define PORT_RESET 8'h00
`define RATIO_RESET 15'h0000
`define CTL_RESET 8'hce
`define REF_DIV 512
`define PRESCALE 8
`endif

/* common/synth_ctrl_pkg.sv */
package synth_ctrl_pkg;
    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_addr = 6'h02,
        st_ack = 6'h04,
        st_wr = 6'h08,
        st_rd = 6'h10,
        st_rdack = 6'h20
    } bus_state_e;
    typedef enum logic [1:0] {
        wb_first = 2'h0,
        wb_lower = 2'h1,
        wb_port = 2'h2
    } wr_slot_e;
endpackage

/* rtl/tuning_synth_i2c_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_regs.svh"
module tuning_synth_i2c_control #(
    parameter int REF_DIV = `REF_DIV
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    input wire logic [1:0] port3_band_in,
    input wire logic [7:0] port_level_in,
    input wire logic [2:0] adc_code_in,
    input wire logic lock_in,
    input wire logic ref_clk_in,
    input wire logic div_out_in,
    output logic [7:0] port_on_out,
    output logic port6_test_out,
    output logic port7_test_out,
    output logic [14:0] ratio_out,
    output logic pump_current_select_out,
    output logic pump_disable_out,
    output logic drive_amp_off_out,
    output logic comparison_clock_out,
    output logic test_mode_out
);
    import synth_ctrl_pkg::*;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] scl_s1;
        logic [1:0] scl_s2;
        logic [1:0] sda_s1;
        logic [1:0] sda_s2;
        logic [1:0] ref_s1;
        logic [1:0] ref_s2;
        logic [1:0] divo_s1;
        logic [1:0] divo_s2;
        logic [13:0] sync_in;
        logic [13:0] in_s;
        bus_state_e st;
        wr_slot_e slot;
        logic [7:0] shreg;
        logic [3:0] nbit;
        logic rd_mode;
        logic was_read;
        logic sda_oe;
        logic [14:0] ratio;
        logic [6:0] upper_hold;
        logic [7:0] ctl;
        logic [7:0] ports;
        logic supply_loss_flag;
        logic [15:0] ref_cnt;
        logic comp_clk;
        logic p6;
        logic p7;
    } state_s;

    state_s q;
    state_s d;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic sda_v;
    logic addr_ok;
    logic [7:0] status_byte;

    always_comb
    begin
        scl_rise = q.scl_s2[0] && !q.scl_s2[1];
        scl_fall = !q.scl_s2[0] && q.scl_s2[1];
        sda_v = q.sda_s2[0];
        start_c = q.scl_s2[0] && q.scl_s2[1] && q.sda_s2[1] && !q.sda_s2[0];
        stop_c = q.scl_s2[0] && q.scl_s2[1] && !q.sda_s2[1] && q.sda_s2[0];
        // Select band 01 is accepted whatever port3 shows.
        addr_ok = (q.shreg[7:3] == `ADDR_FIXED) &&
            ((q.shreg[2:1] == 2'h1) || (q.shreg[2:1] == q.in_s[13:12]));
        status_byte = {q.supply_loss_flag, q.in_s[0],
            q.in_s[11], q.in_s[9], q.in_s[8],
            q.in_s[3:1]};
    end

    always_comb
    begin
        d = q;
        d.rst_sync = {q.rst_sync[0], 1'b1};
        d.scl_s1 = {q.scl_s1[0], scl_in};
        d.scl_s2 = {q.scl_s2[0], q.scl_s1[1]};
        d.sda_s1 = {q.sda_s1[0], sda_in};
        d.sda_s2 = {q.sda_s2[0], q.sda_s1[1]};
        d.ref_s1 = {q.ref_s1[0], ref_clk_in};
        d.ref_s2 = {q.ref_s2[0], q.ref_s1[1]};
        d.divo_s1 = {q.divo_s1[0], div_out_in};
        d.divo_s2 = {q.divo_s2[0], q.divo_s1[1]};
        d.sync_in = {port3_band_in, port_level_in, adc_code_in, lock_in};
        d.in_s = q.sync_in;
        // Comparison clock toggles every REF_DIV/2 rising reference edges.
        if (q.ref_s2[0] && !q.ref_s2[1])
        begin
            if (q.ref_cnt == 16'(REF_DIV / 2 - 1))
            begin
                d.ref_cnt = 16'h0000;
                d.comp_clk = !q.comp_clk;
            end
            else
            begin
                d.ref_cnt = q.ref_cnt + 16'h0001;
            end
        end
        // Test mode puts phase comparator inputs on port6 and port7.
        d.p6 = q.ctl[`CTL_TEST_BIT] ? q.comp_clk : q.ports[6];
        d.p7 = q.ctl[`CTL_TEST_BIT] ? q.divo_s2[0] : q.ports[7];
        if (start_c)
        begin
            d.st = st_addr;
            d.nbit = 4'h0;
            d.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            // A stop mid-byte drops the partial byte.
            d.st = st_idle;
            d.sda_oe = 1'b0;
            if (q.was_read)
            begin
                d.supply_loss_flag = 1'b0;
            end
            d.was_read = 1'b0;
        end
        else
        begin
            case (q.st)
                st_idle:
                begin
                    d.sda_oe = 1'b0;
                end
                st_addr, st_wr:
                begin
                    if (scl_rise)
                    begin
                        d.shreg = {q.shreg[6:0], sda_v};
                        d.nbit = q.nbit + 4'h1;
                    end
                    else if (scl_fall && q.nbit == 4'h8)
                    begin
                        d.nbit = 4'h0;
                        if (q.st == st_addr)
                        begin
                            if (addr_ok)
                            begin
                                d.sda_oe = 1'b1;
                                d.rd_mode = q.shreg[0];
                                d.was_read = q.shreg[0];
                                d.slot = wb_first;
                                d.st = st_ack;
                            end
                            else
                            begin
                                d.st = st_idle;
                            end
                        end
                        else
                        begin
                            d.sda_oe = 1'b1;
                            d.st = st_ack;
                            case (q.slot)
                                wb_first:
                                begin
                                    if (!q.shreg[7])
                                    begin
                                        d.upper_hold = q.shreg[6:0];
                                        d.slot = wb_lower;
                                    end
                                    else
                                    begin
                                        d.ctl = q.shreg;
                                        d.slot = wb_port;
                                    end
                                end
                                wb_lower:
                                begin
                                    d.ratio = {q.upper_hold, q.shreg};
                                    d.slot = wb_first;
                                end
                                wb_port:
                                begin
                                    d.ports = q.shreg;
                                    d.slot = wb_first;
                                end
                                default:
                                begin
                                    d.slot = wb_first;
                                end
                            endcase
                        end
                    end
                end
                st_ack:
                begin
                    if (scl_fall)
                    begin
                        d.sda_oe = 1'b0;
                        if (q.rd_mode)
                        begin
                            d.shreg = status_byte;
                            d.nbit = 4'h0;
                            d.sda_oe = !status_byte[7];
                            d.st = st_rd;
                        end
                        else
                        begin
                            d.st = st_wr;
                        end
                    end
                end
                st_rd:
                begin
                    if (scl_fall)
                    begin
                        if (q.nbit == 4'h7)
                        begin
                            d.sda_oe = 1'b0;
                            d.st = st_rdack;
                        end
                        else
                        begin
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.sda_oe = !q.shreg[6];
                            d.nbit = q.nbit + 4'h1;
                        end
                    end
                end
                st_rdack:
                begin
                    if (scl_rise)
                    begin
                        // Master low on the ack slot asks for another status byte.
                        d.st = sda_v ? st_idle : st_ack;
                    end
                end
                default:
                begin
                    d.st = st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q <= '0;
            q.st <= st_idle;
            q.slot <= wb_first;
            q.ctl <= `CTL_RESET;
            q.ports <= `PORT_RESET;
            q.ratio <= `RATIO_RESET;
            q.scl_s1 <= 2'h3;
            q.scl_s2 <= 2'h3;
            q.sda_s1 <= 2'h3;
            q.sda_s2 <= 2'h3;
            q.supply_loss_flag <= 1'b1;
        end
        else if (!q.rst_sync[1])
        begin
            q.rst_sync <= d.rst_sync;
        end
        else
        begin
            q <= d;
        end
    end

    always_comb
    begin
        sda_oe_out = q.sda_oe;
        port_on_out = q.ports;
        port6_test_out = q.p6;
        port7_test_out = q.p7;
        ratio_out = q.ratio;
        pump_current_select_out = q.ctl[`CTL_PUMP_CUR_BIT];
        pump_disable_out = q.ctl[`CTL_PUMP_DIS_BIT];
        drive_amp_off_out = q.ctl[`CTL_AMP_OFF_BIT];
        comparison_clock_out = q.comp_clk;
        test_mode_out = q.ctl[`CTL_TEST_BIT];
    end

    // The eighth address bit has been taken and the bus is otherwise quiet.
    sequence addr_done_s;
        q.st == st_addr && scl_fall && q.nbit == 4'h8 && !start_c && !stop_c && q.rst_sync[1];
    endsequence
    sequence rd_ack_done_s;
        q.st == st_ack && scl_fall && q.rd_mode && !start_c && !stop_c && q.rst_sync[1];
    endsequence

    stop_clears_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (stop_c && q.was_read && q.rst_sync[1]) |=> !q.supply_loss_flag)
        else $error("Supply loss flag not cleared by stop after read.");
    addr_ack_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (addr_done_s ##0 addr_ok) |=> sda_oe_out)
        else $error("Matching address not acknowledged.");
    addr_refuse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (addr_done_s ##0 !addr_ok) |=> (q.st == st_idle && !sda_oe_out))
        else $error("Non-matching address acknowledged.");
    ratio_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $changed(ratio_out) |-> $past(q.slot) == wb_lower)
        else $error("Ratio changed outside lower byte.");
    port_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $changed(port_on_out) |-> $past(q.slot) == wb_port)
        else $error("Port outputs changed outside port byte.");
    test_route_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        q.ctl[`CTL_TEST_BIT] |=> port6_test_out == $past(q.comp_clk))
        else $error("Comparison clock not routed to port6.");
    status_msb_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        rd_ack_done_s |=> sda_oe_out == !$past(q.supply_loss_flag))
        else $error("Status MSB does not show supply loss flag.");
endmodule // tuning_synth_i2c_control
`default_nettype wire

/* tb/bus_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_drv_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    task automatic quarter();
        repeat (8) @(posedge clk_in);
        #1;
    endtask
    task automatic bit_cell(input logic v, output logic s);
        sda_drv_out = v;
        quarter();
        scl_out = 1'b1;
        quarter();
        s = sda_in;
        quarter();
        scl_out = 1'b0;
        quarter();
    endtask
    task automatic start();
        sda_drv_out = 1'b1;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_drv_out = 1'b0;
        quarter();
        scl_out = 1'b0;
        quarter();
    endtask
    task automatic stop();
        sda_drv_out = 1'b0;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_drv_out = 1'b1;
        quarter();
    endtask
    task automatic send_bits(input logic [7:0] b, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--)
        begin
            bit_cell(b[i], s);
        end
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        send_bits(b, 8);
        bit_cell(1'b1, ack);
    endtask
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cell(1'b1, d[i]);
        end
        bit_cell(~more, s);
    endtask
endmodule // bus_master_model
`default_nettype wire

/* tb/tuning_synth_i2c_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tuning_synth_i2c_control_bench;
    import synth_ctrl_pkg::*;
    localparam int REF_DIV_SIM = 8;
    localparam int REF_HALF = 5;
    logic clk_in = 1'b0;
    logic rst_b_in, scl, sda_drv, sda_oe, ref_clk_in, lock_in, div_out_in;
    logic [1:0] port3_band_in;
    logic [7:0] port_level_in, port_on;
    logic [2:0] adc_code_in;
    logic p6_test, p7_test, pump_cur, pump_dis, amp_off, comp_clk, test_mode;
    logic [14:0] ratio;
    wire logic sda_bus = sda_drv & ~sda_oe;
    int err_total = 0;
    int checked = 0;
    int ref_cnt = 0;
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        #1;
        ref_cnt = (ref_cnt + 1) % REF_HALF;
        if (ref_cnt == 0)
            ref_clk_in = ~ref_clk_in;
    end
    bus_master_model master (.clk_in(clk_in), .sda_in(sda_bus), .scl_out(scl),
        .sda_drv_out(sda_drv));
    tuning_synth_i2c_control #(.REF_DIV(REF_DIV_SIM)) dut (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_bus), .sda_oe_out(sda_oe),
        .port3_band_in(port3_band_in), .port_level_in(port_level_in),
        .adc_code_in(adc_code_in), .lock_in(lock_in), .ref_clk_in(ref_clk_in),
        .div_out_in(div_out_in), .port_on_out(port_on), .port6_test_out(p6_test),
        .port7_test_out(p7_test), .ratio_out(ratio), .pump_current_select_out(pump_cur),
        .pump_disable_out(pump_dis), .drive_amp_off_out(amp_off),
        .comparison_clock_out(comp_clk), .test_mode_out(test_mode));
    task automatic results();
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic ack;
        master.send_byte(b, ack);
        `CHK("ack", exp_ack, ack)
    endtask
    task automatic wait_cc(input logic v);
        int k;
        k = 0;
        while (comp_clk !== v)
        begin
            @(posedge clk_in);
            #1;
            k++;
            if (k > 2000)
            begin
                err_total++;
                results();
            end
        end
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_in);
        err_total++;
        results();
    end
    initial
    begin
        logic [7:0] d;
        logic [1:0] bands [6];
        logic [1:0] sels [6];
        logic [5:0] nacks;
        time t0;
        bands = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h0, 2'h2};
        sels = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3};
        nacks = 6'b110000;
        rst_b_in = 1'b0;
        ref_clk_in = 1'b0;
        lock_in = 1'b1;
        div_out_in = 1'b0;
        port3_band_in = 2'h0;
        port_level_in = 8'ha0;
        adc_code_in = 3'h4;
        repeat (4) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        repeat (20) @(posedge clk_in);
        #1;
        `CHK("port_on", 8'h00, port_on)
        `CHK("pump_cur", 1'b1, pump_cur)
        master.start();
        put(8'hc2, 1'b0);
        put(8'h12, 1'b0);
        put(8'h34, 1'b0);
        put(8'hbf, 1'b0);
        put(8'h5a, 1'b0);
        master.stop();
        `CHK("ratio", 15'h1234, ratio)
        `CHK("pump_cur", 1'b0, pump_cur)
        `CHK("pump_dis", 1'b1, pump_dis)
        `CHK("amp_off", 1'b1, amp_off)
        `CHK("test_mode", 1'b1, test_mode)
        `CHK("port_on", 8'h5a, port_on)
        div_out_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        `CHK("p7_test", 1'b1, p7_test)
        div_out_in = 1'b0;
        wait_cc(1'b0);
        wait_cc(1'b1);
        t0 = $time;
        @(posedge clk_in);
        #1;
        `CHK("p6_test", 1'b1, p6_test)
        wait_cc(1'b0);
        @(posedge clk_in);
        #1;
        `CHK("p6_test", 1'b0, p6_test)
        `CHK("p7_test", 1'b0, p7_test)
        wait_cc(1'b1);
        `CHK("comp_period", REF_DIV_SIM * REF_HALF * 8, int'($time - t0))
        master.start();
        put(8'hc2, 1'b0);
        put(8'h8e, 1'b0);
        put(8'h00, 1'b0);
        put(8'h05, 1'b0);
        master.send_bits(8'hff, 4);
        master.stop();
        `CHK("ratio", 15'h1234, ratio)
        `CHK("port_on", 8'h00, port_on)
        `CHK("test_mode", 1'b0, test_mode)
        `CHK("pump_cur", 1'b0, pump_cur)
        for (int i = 0; i < 6; i++)
        begin
            port3_band_in = bands[i];
            master.start();
            put({5'h18, sels[i], 1'b0}, nacks[i]);
            master.stop();
        end
        port3_band_in = 2'h0;
        master.start();
        put(8'hc3, 1'b0);
        master.recv_byte(1'b1, d);
        `CHK("status", 8'hf4, d)
        master.recv_byte(1'b0, d);
        `CHK("status", 8'hf4, d)
        master.stop();
        lock_in = 1'b0;
        adc_code_in = 3'h3;
        port_level_in = 8'h30;
        master.start();
        put(8'hc3, 1'b0);
        master.recv_byte(1'b0, d);
        `CHK("status", 8'h1b, d)
        master.stop();
        results();
    end
endmodule // tuning_synth_i2c_control_bench
`default_nettype wire
